// ### inc/fpv_pkg.sv
`default_nettype none
package fpv_pkg;
   // ==========================================================================
   // register byte offsets
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_CMD_IDX  = 8'h04;
   localparam logic [7:0] OFS_CMD_WORD = 8'h08;
   localparam logic [7:0] OFS_PF_PROT  = 8'h0C;
   localparam logic [7:0] OFS_EE_PROT  = 8'h10;
   localparam logic [7:0] OFS_CONFIG   = 8'h14;
   // ==========================================================================
   // status register fields
   localparam int ST_CMD_DONE = 7;
   localparam int ST_ACC_ERR  = 5;
   localparam int ST_PVIOL    = 4;
   localparam int ST_MGUP     = 1;
   localparam int ST_MGLO     = 0;
   // ==========================================================================
   // eeprom protection fields
   localparam int EE_OPEN     = 7;
   localparam int SECT_SIZE_W = 5;
   // ==========================================================================
   // config register fields
   localparam int CFG_CCIE  = 0;
   localparam int CFG_ERRIE = 1;
   // ==========================================================================
   // commands and command words
   localparam logic [7:0]  CMD_ERASE_VERIFY = 8'h03;
   localparam logic [7:0]  CMD_READ_ONCE    = 8'h04;
   localparam logic [2:0]  EVS_INDEX        = 3'h2;
   localparam logic [15:0] RO_MAX_INDEX     = 16'h0007;
   localparam int          NUM_WORDS        = 3;
   localparam logic [2:0]  PHRASE_ALIGN     = 3'h0;
   localparam logic [63:0] ERASED_PHRASE    = 64'hFFFF_FFFF_FFFF_FFFF;
   // ==========================================================================
   // reset values
   localparam logic [2:0]  PF_SCEN_RST = 3'h7;
   localparam logic [7:0]  CFG_RST     = 8'h00;
   // allowed scenario moves, bit n of entry m: move from m to n
   localparam logic [7:0] PF_ALLOW [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                                           8'h18, 8'h3C, 8'h5A, 8'hFF};
   // ==========================================================================
   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_CHECK = 4'b0010,
      ST_READ  = 4'b0100,
      ST_DONE  = 4'b1000
   } fpv_state_t;
endpackage
`default_nettype wire

// ### logic/fpv_core.sv
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - normal mode: pflash protection grows only
// - pflash protection reads the active scenario
// - moves from scenarios 0 to 3 limited
// - moves from scenarios 4 to 6 limited, scenario 7 may move to any
// - normal mode: eeprom size grows, open clears
// - open bit set means eeprom unprotected
// - special mode: eeprom protection freely writable
// - eeprom protection loaded from config at reset
// - clearing complete flag launches, completion sets it
// - unerased phrase sets both status bits
// - wrong word index gives access error
// - command unavailable in mode gives access error
// - invalid global address gives access error
// - misaligned start address gives access error
// - section past flash end gives access error
// - any read error sets upper status
// - uncorrectable read error sets lower status
// - read-once returns phrase word zero
// - eeprom reads correct single, detect double
// - interrupts on completion and on access error
module fpv_core #(
   parameter logic [23:0] PF_BASE     = 24'h000000,
   parameter logic [23:0] PF_SIZE     = 24'h010000,
   parameter logic [1:0]  EVS_MODE_OK = 2'b11
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        special_mode_i,
   input  wire logic [7:0]  ee_prot_cfg_i,
   output logic             mem_rd_o,
   output logic             mem_info_o,
   output logic      [23:0] mem_addr_o,
   input  wire logic        mem_ack_i,
   input  wire logic [63:0] mem_data_i,
   input  wire logic        mem_err_i,
   input  wire logic        mem_uncorr_i,
   input  wire logic        ee_valid_i,
   input  wire logic [21:0] ee_code_i,
   output logic             ee_valid_o,
   output logic      [15:0] ee_data_o,
   output logic             ee_corr_o,
   output logic             ee_dbl_o,
   output logic             ee_prot_en_o,
   output logic      [4:0]  ee_prot_size_o,
   output logic             irq_o
);
   // ==========================================================================
   // bus decode
   wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire        wr_lo    = bus_req & wb_we_i & wb_sel_i[0];
   wire        wr_hi    = bus_req & wb_we_i & wb_sel_i[1];
   wire        sel_st   = (wb_adr_i == fpv_pkg::OFS_STATUS);
   wire        sel_idx  = (wb_adr_i == fpv_pkg::OFS_CMD_IDX);
   wire        sel_word = (wb_adr_i == fpv_pkg::OFS_CMD_WORD);
   wire        sel_pf   = (wb_adr_i == fpv_pkg::OFS_PF_PROT);
   wire        sel_ee   = (wb_adr_i == fpv_pkg::OFS_EE_PROT);
   wire        sel_cfg  = (wb_adr_i == fpv_pkg::OFS_CONFIG);

   // ==========================================================================
   // registers
   fpv_pkg::fpv_state_t state_r, state_nxt;
   logic              cmd_done_r;
   logic              acc_err_r;
   logic              mgup_r;
   logic              mglo_r;
   logic [2:0]        idx_r;
   logic [15:0]       cw_r [fpv_pkg::NUM_WORDS];
   logic [2:0]        pf_r;
   logic [7:0]        ee_r;
   logic [7:0]        cfg_r;
   logic [23:0]       cur_addr_r;
   logic [15:0]       remain_r;
   logic              ro_r;
   logic              blank_fail_r;
   logic              rd_err_r;
   logic              uncorr_r;

   // ==========================================================================
   // launch and status flags
   wire launch = wr_lo & sel_st & wb_dat_i[fpv_pkg::ST_CMD_DONE]
               & cmd_done_r & ~acc_err_r;
   wire clr_acc = wr_lo & sel_st & wb_dat_i[fpv_pkg::ST_ACC_ERR];
   wire [7:0]  cmd_code = cw_r[0][15:8];
   wire [23:0] gaddr    = {cw_r[0][7:0], cw_r[1]};
   wire [25:0] pf_limit = {2'b00, PF_BASE} + {2'b00, PF_SIZE};
   wire [25:0] sect_end = {2'b00, gaddr} + {7'b0000000, cw_r[2], 3'b000};
   wire        mode_ok  = special_mode_i ? EVS_MODE_OK[1] : EVS_MODE_OK[0];
   wire        addr_ok  = ({2'b00, gaddr} >= {2'b00, PF_BASE}) && ({2'b00, gaddr} < pf_limit);
   wire        evs_err  = (idx_r != fpv_pkg::EVS_INDEX)
                        | ~mode_ok
                        | ~addr_ok
                        | (gaddr[2:0] != fpv_pkg::PHRASE_ALIGN)
                        | (sect_end > pf_limit);
   wire        ro_err   = (cw_r[1] > fpv_pkg::RO_MAX_INDEX);
   wire        is_evs   = (cmd_code == fpv_pkg::CMD_ERASE_VERIFY);
   wire        is_ro    = (cmd_code == fpv_pkg::CMD_READ_ONCE);
   wire        chk_fail = is_evs ? evs_err : (is_ro ? ro_err : 1'b1);
   wire        chk_st   = (state_r == fpv_pkg::ST_CHECK);
   wire        set_acc  = chk_st & chk_fail;
   wire        go_read  = chk_st & ~chk_fail & (is_ro | (cw_r[2] != 16'h0000));
   wire        rd_st    = (state_r == fpv_pkg::ST_READ);
   wire        last_ack = rd_st & mem_ack_i & (remain_r == 16'h0001);
   wire        done_st  = (state_r == fpv_pkg::ST_DONE);
   wire        finish   = done_st | (chk_st & ~go_read);
   wire        phrase_dirty = mem_data_i != fpv_pkg::ERASED_PHRASE;

   // ==========================================================================
   // sequencer
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         fpv_pkg::ST_IDLE:  if (launch) state_nxt = fpv_pkg::ST_CHECK;
         fpv_pkg::ST_CHECK: state_nxt = go_read ? fpv_pkg::ST_READ : fpv_pkg::ST_IDLE;
         fpv_pkg::ST_READ:  if (last_ack) state_nxt = fpv_pkg::ST_DONE;
         fpv_pkg::ST_DONE:  state_nxt = fpv_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= fpv_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // set wins over clear on complete and access error flags, launch clear wins on mgup/mglo
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_done_r <= 1'b1;
         acc_err_r  <= 1'b0;
         mgup_r     <= 1'b0;
         mglo_r     <= 1'b0;
      end else begin
         cmd_done_r <= (cmd_done_r & ~launch) | finish;
         acc_err_r  <= (acc_err_r & ~clr_acc) | set_acc;
         if (launch) begin
            mgup_r <= 1'b0;
            mglo_r <= 1'b0;
         end else if (done_st) begin
            mgup_r <= blank_fail_r | rd_err_r;
            mglo_r <= blank_fail_r | uncorr_r;
         end
      end
   end

   // ==========================================================================
   // verify and read-once walk
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_addr_r   <= 24'h000000;
         remain_r     <= 16'h0000;
         ro_r         <= 1'b0;
         blank_fail_r <= 1'b0;
         rd_err_r     <= 1'b0;
         uncorr_r     <= 1'b0;
      end else if (go_read) begin
         cur_addr_r   <= is_ro ? {18'h00000, cw_r[1][2:0], 3'b000} : gaddr;
         remain_r     <= is_ro ? 16'h0001 : cw_r[2];
         ro_r         <= is_ro;
         blank_fail_r <= 1'b0;
         rd_err_r     <= 1'b0;
         uncorr_r     <= 1'b0;
      end else if (rd_st & mem_ack_i) begin
         cur_addr_r   <= cur_addr_r + 24'h000008;
         remain_r     <= remain_r - 16'h0001;
         blank_fail_r <= blank_fail_r | (~ro_r & phrase_dirty);
         rd_err_r     <= rd_err_r | mem_err_i | mem_uncorr_i;
         uncorr_r     <= uncorr_r | mem_uncorr_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_rd_o   <= 1'b0;
         mem_info_o <= 1'b0;
         mem_addr_o <= 24'h000000;
      end else begin
         mem_rd_o   <= (state_nxt == fpv_pkg::ST_READ) & ~(rd_st & mem_ack_i);
         mem_info_o <= go_read ? is_ro : mem_info_o;
         mem_addr_o <= go_read ? (is_ro ? {18'h00000, cw_r[1][2:0], 3'b000} : gaddr)
                     : ((rd_st & mem_ack_i) ? cur_addr_r + 24'h000008 : mem_addr_o);
      end
   end

   // ==========================================================================
   // command words and index
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idx_r <= 3'h0;
         for (int i = 0; i < fpv_pkg::NUM_WORDS; i++) begin
            cw_r[i] <= 16'h0000;
         end
      end else begin
         if (wr_lo & sel_idx) idx_r <= wb_dat_i[2:0];
         for (int i = 0; i < fpv_pkg::NUM_WORDS; i++) begin
            if (sel_word & (idx_r == 3'(i)) & ~rd_st) begin
               if (wr_lo) cw_r[i][7:0]  <= wb_dat_i[7:0];
               if (wr_hi) cw_r[i][15:8] <= wb_dat_i[15:8];
            end
         end
         if (last_ack & ro_r) cw_r[2] <= mem_data_i[15:0];
      end
   end

   // ==========================================================================
   // protection registers
   wire [4:0] size_new = wb_dat_i[fpv_pkg::SECT_SIZE_W-1:0];
   wire [4:0] size_old = ee_r[fpv_pkg::SECT_SIZE_W-1:0];
   wire       open_new = wb_dat_i[fpv_pkg::EE_OPEN];
   wire       open_old = ee_r[fpv_pkg::EE_OPEN];
   wire       open_ok  = open_old | ~open_new;
   wire       ee_ok    = special_mode_i
                       | (open_ok & ((size_new > size_old)
                       | ((size_new == size_old) & open_old & ~open_new)));
   wire [7:0] pf_row   = fpv_pkg::PF_ALLOW[pf_r];
   wire       pf_ok    = special_mode_i | pf_row[wb_dat_i[2:0]];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pf_r  <= fpv_pkg::PF_SCEN_RST;
         ee_r  <= ee_prot_cfg_i & 8'h9F;
         cfg_r <= fpv_pkg::CFG_RST;
      end else begin
         if (wr_lo & sel_pf & pf_ok) pf_r <= wb_dat_i[2:0];
         if (wr_lo & sel_ee & ee_ok) ee_r <= wb_dat_i[7:0] & 8'h9F;
         if (wr_lo & sel_cfg) cfg_r <= {6'h00, wb_dat_i[1:0]};
      end
   end

   // ==========================================================================
   // bus answer, one wait state
   wire [7:0]  st_val = {cmd_done_r, 1'b0, acc_err_r, 1'b0, 2'b00, mgup_r, mglo_r};
   wire [15:0] word_val = (idx_r < 3'(fpv_pkg::NUM_WORDS)) ? cw_r[idx_r[1:0]] : 16'h0000;
   wire [31:0] rd_mux = sel_st   ? {24'h000000, st_val}
                      : sel_idx  ? {29'h00000000, idx_r}
                      : sel_word ? {16'h0000, word_val}
                      : sel_pf   ? {29'h00000000, pf_r}
                      : sel_ee   ? {24'h000000, ee_r}
                      : sel_cfg  ? {24'h000000, cfg_r}
                      : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
      end
   end

   // ==========================================================================
   // eeprom secded decode
   function automatic logic [18:0] ecc_fix(input logic [21:0] cw);
      logic [4:0]  syn;
      logic [21:0] fx;
      logic [15:0] d;
      int          k;
      syn = 5'h00;
      fx  = cw;
      d   = 16'h0000;
      k   = 0;
      for (int i = 1; i < 22; i++) begin
         if (cw[i]) syn = syn ^ 5'(i);
      end
      if ((syn != 5'h00) && (^cw) && (syn < 5'h16)) fx[syn] = ~fx[syn];
      for (int i = 3; i < 22; i++) begin
         if ((i != 4) && (i != 8) && (i != 16)) begin
            d[k] = fx[i];
            k = k + 1;
         end
      end
      ecc_fix = {(^cw), ((syn != 5'h00) & ~(^cw)), 1'b0, d};
   endfunction

   wire [18:0] ecc_res = ecc_fix(ee_code_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ee_valid_o <= 1'b0;
         ee_data_o  <= 16'h0000;
         ee_corr_o  <= 1'b0;
         ee_dbl_o   <= 1'b0;
      end else begin
         ee_valid_o <= ee_valid_i;
         if (ee_valid_i) begin
            ee_data_o <= ecc_res[15:0];
            ee_corr_o <= ecc_res[18];
            ee_dbl_o  <= ecc_res[17];
         end
      end
   end

   // ==========================================================================
   // effective eeprom protection and interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ee_prot_en_o   <= 1'b0;
         ee_prot_size_o <= 5'h00;
         irq_o          <= 1'b0;
      end else begin
         ee_prot_en_o   <= ~open_old;
         ee_prot_size_o <= open_old ? 5'h00 : size_old;
         irq_o          <= (cfg_r[fpv_pkg::CFG_CCIE] & cmd_done_r)
                         | (cfg_r[fpv_pkg::CFG_ERRIE] & acc_err_r);
      end
   end

   // ==========================================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_evs_launch;
      launch & is_evs;
   endsequence

   chk_pf_only_grows: assert property (
      wr_lo & sel_pf & ~special_mode_i & ~pf_row[wb_dat_i[2:0]] |=> $stable(pf_r))
      else $error("rejected pflash protection write took effect");

   chk_pf_read_active: assert property (
      bus_req & ~wb_we_i & sel_pf |=> wb_ack_o && wb_dat_o == {29'h00000000, $past(pf_r)})
      else $error("pflash protection read does not show active scenario");

   chk_pf_move_legal: assert property (
      ~$past(special_mode_i) & (pf_r != $past(pf_r)) |-> fpv_pkg::PF_ALLOW[$past(pf_r)][pf_r])
      else $error("illegal pflash scenario move");

   chk_pf_from_seven: assert property (
      wr_lo & sel_pf & (pf_r == 3'h7) |=> pf_r == $past(wb_dat_i[2:0]))
      else $error("scenario 7 did not accept a move");

   chk_ee_add_only: assert property (
      ~$past(special_mode_i) & (ee_r != $past(ee_r))
      |-> (ee_r[4:0] >= $past(ee_r[4:0])) && !(ee_r[7] && !$past(ee_r[7])))
      else $error("eeprom protection was reduced in normal mode");

   chk_ee_open_free: assert property (
      ee_r[fpv_pkg::EE_OPEN] |=> !ee_prot_en_o && ee_prot_size_o == 5'h00)
      else $error("open eeprom still shows protection");

   chk_ee_special_wr: assert property (
      wr_lo & sel_ee & special_mode_i |=> ee_r == ($past(wb_dat_i[7:0]) & 8'h9F))
      else $error("special mode eeprom protection write lost");

   chk_launch_done: assert property (
      launch |=> !cmd_done_r ##1 (cmd_done_r ^ rd_st))
      else $error("launch did not clear complete flag");

   chk_index_error: assert property (
      s_evs_launch ##0 (idx_r != fpv_pkg::EVS_INDEX) |-> ##2 acc_err_r && cmd_done_r)
      else $error("wrong index did not raise access error");

   chk_blank_fail: assert property (
      done_st & blank_fail_r & ~launch |=> mgup_r && mglo_r)
      else $error("blank check failure not flagged");

   chk_clean_verify: assert property (
      done_st & ~blank_fail_r & ~rd_err_r & ~uncorr_r |=> !mgup_r && !mglo_r && cmd_done_r)
      else $error("clean verify left status bits set");
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // ==========================================================================
   // stimulus and observed signals
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, special_mode_i;
   logic        mem_rd_o, mem_info_o, mem_ack_i, mem_err_i, mem_uncorr_i, ee_valid_i;
   logic        ee_valid_o, ee_corr_o, ee_dbl_o, ee_prot_en_o, irq_o;
   logic        exp_info, inj_err, inj_unc;
   logic [7:0]  wb_adr_i, ee_prot_cfg_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [23:0] mem_addr_o, exp_addr;
   logic [63:0] mem_data_i, phrase_val;
   logic [21:0] ee_code_i;
   logic [15:0] ee_data_o;
   logic [4:0]  ee_prot_size_o;
   int          error_cnt, num_checks, rd_cnt, bad_idx, cyc_cnt;
   integer      seed;
   localparam logic [7:0] A_ST = fpv_pkg::OFS_STATUS;
   localparam logic [7:0] A_IX = fpv_pkg::OFS_CMD_IDX;
   localparam logic [7:0] A_WD = fpv_pkg::OFS_CMD_WORD;
   localparam logic [7:0] A_PF = fpv_pkg::OFS_PF_PROT;
   localparam logic [7:0] A_EE = fpv_pkg::OFS_EE_PROT;

   // only normal mode may run the section verify here
   fpv_core #(.EVS_MODE_OK(2'b01)) fpv_core_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .special_mode_i(special_mode_i),
      .ee_prot_cfg_i(ee_prot_cfg_i), .mem_rd_o(mem_rd_o), .mem_info_o(mem_info_o),
      .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i),
      .mem_err_i(mem_err_i), .mem_uncorr_i(mem_uncorr_i), .ee_valid_i(ee_valid_i),
      .ee_code_i(ee_code_i), .ee_valid_o(ee_valid_o), .ee_data_o(ee_data_o),
      .ee_corr_o(ee_corr_o), .ee_dbl_o(ee_dbl_o), .ee_prot_en_o(ee_prot_en_o),
      .ee_prot_size_o(ee_prot_size_o), .irq_o(irq_o));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ==========================================================================
   // checking and bus tasks
   task automatic complete_run();
      if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= (a == A_WD) ? 4'h3 : 4'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) chk("wb_ack", 32'h0, 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic do_reset(input logic [7:0] cfg);
      ee_prot_cfg_i <= cfg;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic run_cmd(input logic [7:0] code, input logic [2:0] ix, input logic [23:0] a,
                          input logic [15:0] w2, output logic [31:0] fst, output logic [31:0] st);
      int k;
      wr(A_ST, 32'h0000_0020);
      wr(A_IX, 32'h0);
      wr(A_WD, {16'h0, code, a[23:16]});
      wr(A_IX, 32'h1);
      wr(A_WD, {16'h0, a[15:0]});
      wr(A_IX, 32'h2);
      wr(A_WD, {16'h0, w2});
      wr(A_IX, {29'h0, ix});
      rd_cnt = 0;
      wr(A_ST, 32'h0000_0080);
      wb(1'b0, A_ST, 32'h0, fst);
      st = fst;
      k = 0;
      while (st[7] !== 1'b1 && k < 100) begin
         wb(1'b0, A_ST, 32'h0, st);
         k++;
      end
   endtask

   task automatic evs(input logic [2:0] ix, input logic [23:0] a, input logic [15:0] n,
                      input int bad, input logic e, input logic u, input logic sp,
                      input logic [7:0] exp_st);
      logic [31:0] fst, st;
      special_mode_i <= sp;
      bad_idx = bad;
      inj_err = e;
      inj_unc = u;
      phrase_val = 64'hFFFF_FFFF_FFFF_FFFF;
      exp_addr = a;
      exp_info = 1'b0;
      run_cmd(8'h03, ix, a, n, fst, st);
      chk("evs_status", st & 32'hB3, {24'h0, exp_st});
      if (exp_st == 8'h80) chk("evs_reads", rd_cnt, {16'h0, n});
      if (exp_st[5]) chk("evs_reads", rd_cnt, 32'h0);
      if (n > 0 && !exp_st[5]) chk("done_busy", {31'h0, fst[7]}, 32'h0);
      @(posedge clk_i);
      #1 chk("irq", {31'h0, irq_o}, {31'h0, exp_st[5]});
   endtask

   // ==========================================================================
   // expectation functions
   function automatic logic pf_ok(input int m, input int n);
      case (m)
         0: return n <= 3;
         1: return n == 1 || n == 3;
         2: return n == 2 || n == 3;
         3: return n == 3;
         4: return n == 3 || n == 4;
         5: return n >= 2 && n <= 5;
         6: return n == 1 || n == 3 || n == 4 || n == 6;
         default: return 1'b1;
      endcase
   endfunction

   function automatic logic [7:0] ee_next(input logic sp, input logic [7:0] cur,
                                          input logic [7:0] wv);
      logic [7:0] w;
      w = wv & 8'h9F;
      if (sp) return w;
      if (!cur[7] && w[7]) return cur;
      if (w[4:0] > cur[4:0] || (w[4:0] == cur[4:0] && cur[7] && !w[7])) return w;
      return cur;
   endfunction

   function automatic logic [21:0] enc(input logic [15:0] d);
      logic [21:0] c;
      int j;
      c = '0;
      j = 0;
      for (int p = 1; p < 22; p++) begin
         if ((p & (p - 1)) != 0) begin
            c[p] = d[j];
            j++;
         end
      end
      for (int k = 0; k < 5; k++) begin
         for (int p = 1; p < 22; p++) begin
            if (p[k] && p != (1 << k)) c[1 << k] ^= c[p];
         end
      end
      c[0] = ^c[21:1];
      return c;
   endfunction

   // ==========================================================================
   // flash side answers after a random delay
   always @(posedge clk_i) begin
      mem_ack_i <= 1'b0;
      if (mem_rd_o === 1'b1 && mem_ack_i !== 1'b1 && ($random(seed) & 3) == 0) begin
         chk("mem_addr", {8'h0, mem_addr_o}, {8'h0, exp_addr});
         chk("mem_info", {31'h0, mem_info_o}, {31'h0, exp_info});
         mem_ack_i <= 1'b1;
         mem_data_i <= (rd_cnt == bad_idx) ? phrase_val ^ 64'h1 : phrase_val;
         mem_err_i <= inj_err;
         mem_uncorr_i <= inj_unc;
         exp_addr = exp_addr + 24'h8;
         rd_cnt++;
      end
   end

   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 30000) begin
         error_cnt++;
         complete_run();
      end
   end

   // ==========================================================================
   // main sequence
   initial begin
      logic [31:0] q, fst, st;
      logic [7:0]  c, w, e;
      logic [15:0] d;
      logic [21:0] cw;
      int          k, p1;
      seed = 32'h2EC9;
      {wb_cyc_i, wb_stb_i, wb_we_i, special_mode_i, mem_ack_i, mem_err_i} = '0;
      {mem_uncorr_i, ee_valid_i, inj_err, inj_unc, exp_info} = '0;
      {wb_adr_i, wb_sel_i, wb_dat_i, ee_code_i, mem_data_i, exp_addr} = '0;
      {error_cnt, num_checks, rd_cnt, cyc_cnt} = '0;
      bad_idx = -1;
      phrase_val = '1;
      rst_i = 1'b1;
      ee_prot_cfg_i = 8'h00;
      for (int sp = 0; sp < 2; sp++) begin
         for (int m = 0; m < 8; m++) begin
            for (int n = 0; n < 8; n++) begin
               special_mode_i <= sp[0];
               do_reset(8'h00);
               wr(A_PF, m);
               wr(A_PF, n);
               wb(1'b0, A_PF, 32'h0, q);
               chk("pf_prot", q & 32'h7, (sp || pf_ok(m, n)) ? n : m);
            end
         end
      end
      for (int i = 0; i < 32; i++) begin
         c = 8'($random(seed));
         w = 8'($random(seed));
         special_mode_i <= i[0];
         do_reset(c);
         wb(1'b0, A_ST, 32'h0, q);
         chk("status_rst", q & 32'hB3, 32'h80);
         wb(1'b0, A_EE, 32'h0, q);
         chk("ee_rst", q, {24'h0, c & 8'h9F});
         wr(8'hF0, $random(seed));
         wb(1'b0, 8'hF0, 32'h0, q);
         chk("unmapped", q, 32'h0);
         wr(A_EE, {24'h0, w});
         wb(1'b0, A_EE, 32'h0, q);
         e = ee_next(i[0], c & 8'h9F, w);
         chk("ee_prot", q, {24'h0, e});
         #1 chk("ee_prot_en", {31'h0, ee_prot_en_o}, {31'h0, !e[7]});
         chk("ee_prot_size", {27'h0, ee_prot_size_o}, e[7] ? 32'h0 : {27'h0, e[4:0]});
      end
      special_mode_i <= 1'b0;
      wr(fpv_pkg::OFS_CONFIG, 32'h1);
      @(posedge clk_i);
      #1 chk("irq_cc", {31'h0, irq_o}, 32'h1);
      wr(fpv_pkg::OFS_CONFIG, 32'h2);
      evs(3'h2, 24'h000100, 16'h3, -1, 1'b0, 1'b0, 1'b0, 8'h80);
      evs(3'h2, 24'h000200, 16'h0, -1, 1'b0, 1'b0, 1'b0, 8'h80);
      evs(3'h2, 24'h000000, 16'h3, 1, 1'b0, 1'b0, 1'b0, 8'h83);
      evs(3'h2, 24'h00FFF0, 16'h2, -1, 1'b1, 1'b0, 1'b0, 8'h82);
      evs(3'h2, 24'h000008, 16'h1, -1, 1'b1, 1'b1, 1'b0, 8'h83);
      evs(3'h1, 24'h000100, 16'h1, -1, 1'b0, 1'b0, 1'b0, 8'hA0);
      evs(3'h2, 24'h000100, 16'h1, -1, 1'b0, 1'b0, 1'b1, 8'hA0);
      evs(3'h2, 24'h010000, 16'h1, -1, 1'b0, 1'b0, 1'b0, 8'hA0);
      evs(3'h2, 24'h000104, 16'h1, -1, 1'b0, 1'b0, 1'b0, 8'hA0);
      evs(3'h2, 24'h00FFF8, 16'h2, -1, 1'b0, 1'b0, 1'b0, 8'hA0);
      special_mode_i <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         d = 16'($random(seed));
         phrase_val = {$random(seed), ~d, d};
         exp_addr = 24'(i * 8);
         exp_info = 1'b1;
         {inj_err, inj_unc} = '0;
         bad_idx = -1;
         run_cmd(8'h04, 3'h2, 24'(i), 16'h0, fst, st);
         wr(A_IX, 32'h2);
         wb(1'b0, A_WD, 32'h0, q);
         chk("ro_status", st & 32'hB3, (i < 8) ? 32'h80 : 32'hA0);
         if (i < 8) chk("ro_word", {16'h0, q[15:0]}, {16'h0, d});
      end
      for (int i = 0; i < 30; i++) begin
         d = 16'($random(seed));
         k = i % 3;
         cw = enc(d);
         p1 = ($random(seed) & 32'h7FFF_FFFF) % 22;
         if (k > 0) cw[p1] = ~cw[p1];
         if (k > 1) cw[(p1 + 1 + ($random(seed) & 32'hF)) % 22] ^= 1'b1;
         @(posedge clk_i);
         ee_valid_i <= 1'b1;
         ee_code_i <= cw;
         @(posedge clk_i);
         ee_valid_i <= 1'b0;
         #1 chk("ee_valid", {31'h0, ee_valid_o}, 32'h1);
         chk("ee_corr", {31'h0, ee_corr_o}, {31'h0, k == 1});
         chk("ee_dbl", {31'h0, ee_dbl_o}, {31'h0, k == 2});
         if (k < 2) chk("ee_data", {16'h0, ee_data_o}, {16'h0, d});
      end
      complete_run();
   end
endmodule
`default_nettype wire
